// ===== pkg/ccp_pkg.sv
// Shared constants, types and decode functions of the codec control port slave.
package ccp_pkg;

	// ****************************************************************
	// Widths and counts
	// ****************************************************************
	localparam int          SUB_W           = 16;
	localparam int          BYTE_W          = 8;
	localparam int          SYNC_W          = 6;
	localparam logic [3:0]  BITS_PER_SLOT   = 4'h8;
	localparam logic [2:0]  LINK_LAST_BIT   = 3'h7;
	localparam logic [1:0]  SPI_DATA_BYTE   = 2'h3;
	localparam logic [1:0]  SPI_ENTRY_FALLS = 2'h3;

	// ****************************************************************
	// Device address and memory map
	// ****************************************************************
	localparam logic [4:0]  DEV_ADDR_UPPER  = 5'h0F;
	localparam logic [15:0] PARAM_LO        = 16'h0080;
	localparam logic [15:0] PARAM_HI        = 16'h021F;
	localparam logic [15:0] PROG_LO         = 16'h0400;
	localparam logic [15:0] PROG_HI         = 16'h041F;
	localparam logic [15:0] REG_LO          = 16'hC000;
	localparam logic [15:0] REG_HI          = 16'hC040;
	localparam logic [15:0] SUB_HIGHEST     = REG_HI;
	localparam logic [2:0]  WLEN_REG        = 3'h1;
	localparam logic [2:0]  WLEN_PROG       = 3'h2;
	localparam logic [2:0]  WLEN_PARAM      = 3'h4;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	// Synchroniser order: power down, select, address one, data, clock, toggle.
	localparam logic [5:0]  SYNC_RST        = 6'h3E;
	localparam logic [15:0] SUB_RST         = 16'h0000;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {I2_IDLE, I2_RX, I2_ACK, I2_TX, I2_MACK} ccp_i2c_e;
	typedef enum logic [1:0] {PH_CTRL, PH_SUBH, PH_SUBL, PH_DATA} ccp_phase_e;

	// ****************************************************************
	// Subaddress decode
	// ****************************************************************
	function automatic logic [2:0] ccp_word_len(input logic [15:0] sub);
		if (sub >= PARAM_LO && sub <= PARAM_HI) begin
			return WLEN_PARAM;
		end
		if (sub >= PROG_LO && sub <= PROG_HI) begin
			return WLEN_PROG;
		end
		return WLEN_REG;
	endfunction : ccp_word_len

	function automatic logic ccp_sub_valid(input logic [15:0] sub);
		return (sub >= PARAM_LO && sub <= PARAM_HI) || (sub >= PROG_LO && sub <= PROG_HI)
			|| (sub >= REG_LO && sub <= REG_HI);
	endfunction : ccp_sub_valid

endpackage : ccp_pkg

// ===== pkg/ccp_pin_if.sv
// Raw pin levels into the synchroniser and their settled values back out.
`timescale 1ns/1ps
interface ccp_pin_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface : ccp_pin_if

// ===== rtl/ccp_sync.sv
// Three-stage input synchroniser that accepts a level once stages two and three agree.
`timescale 1ns/1ps
module ccp_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clocking
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic sys_ce,
	// Pins in, settled levels out
	ccp_pin_if.sync   pins
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] clean_r;
	logic [W-1:0] differ;
	logic [W-1:0] clean_nxt;

	if (W < 1) begin : g_bad_width
		$error("ccp_sync needs at least one bit");
	end

	// A bit still moving between stages two and three keeps its old settled value.
	assign differ    = s2_r ^ s3_r;
	assign clean_nxt = (s3_r & ~differ) | (clean_r & differ);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s1_r    <= RST_VAL;
			s2_r    <= RST_VAL;
			s3_r    <= RST_VAL;
			clean_r <= RST_VAL;
		end else if (sys_ce) begin
			s1_r    <= pins.raw;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			clean_r <= clean_nxt;
		end
	end

	assign pins.clean = clean_r;

endmodule : ccp_sync

// ===== rtl/ccp_port.sv
// Codec control port slave: I2C by default, 4-wire SPI after three selects.
`timescale 1ns/1ps
module ccp_port (
	// System clock domain
	input  wire logic                          sys_clk,
	input  wire logic                          sys_rst,
	input  wire logic                          sys_ce,
	// Control port pins; link_clk is SCL in I2C mode and SCLK in SPI mode
	input  wire logic                          link_clk,
	input  wire logic                          sda_miso_in,
	input  wire logic                          addr_select_bit_one,
	input  wire logic                          addr_select_bit_zero,
	input  wire logic                          power_down_n_pin,
	output logic                               i2c_sda_out,
	output logic                               i2c_sda_oe,
	output logic                               spi_miso_out,
	output logic                               spi_miso_oe,
	// Status
	output logic                               spi_mode,
	// Memory and register access
	output logic                               mem_wr,
	output logic                               mem_rd,
	output logic [ccp_pkg::SUB_W-1:0]          mem_addr,
	output logic [1:0]                         mem_byte,
	output logic [ccp_pkg::BYTE_W-1:0]         mem_wdata,
	input  wire logic [ccp_pkg::BYTE_W-1:0]    mem_rdata
);
	import ccp_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	ccp_i2c_e                i2c_st_r;
	ccp_phase_e              phase_r;
	ccp_phase_e              phase_nxt;
	logic                    scl_s, sda_s, a1_s, ss_n_s, pd_n_s, tgl_s;
	logic                    scl_q_r, sda_q_r, ss_q_r, tgl_q_r;
	logic                    scl_rise, scl_fall, start_c, stop_c, ss_fall, ss_rise;
	logic                    i2c_act, i2c_evt, spi_evt, evt, accept, take, frame_reset;
	logic                    addr_match, wr_over, wr_go, rd_go, mack_ok, step, word_end;
	logic                    sub_load;
	logic [2:0]              cur_len;
	logic [1:0]              cur_bidx;
	logic [15:0]             cur_sub;
	logic                    hold_top, rd_r, spi_mode_r, spi_live_r, sda_oe_r, sda_out_r;
	logic [1:0]              spi_cnt_r, bidx_r, bidx_nxt;
	logic [2:0]              wlen_r;
	logic [3:0]              bitc_r;
	logic [7:0]              shift_r, txsh_r, evt_byte, tx_byte_r;
	logic [15:0]             sub_r, sub_step, full_sub;
	logic                    mem_wr_r, mem_rd_r;
	logic [15:0]             mem_addr_r;
	logic [1:0]              mem_byte_r;
	logic [7:0]              mem_wdata_r;
	logic                    link_frame_rst, link_mode_rst;
	logic [2:0]              bitl_r;
	logic [1:0]              bytel_r;
	logic [6:0]              rx_sh_r;
	logic [7:0]              rx_hold_r, txl_r;
	logic                    rx_tgl_r, rdl_r, miso_r, miso_oe_r;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	ccp_pin_if #(.W(SYNC_W)) pin_if ();

	assign pin_if.raw = {power_down_n_pin, addr_select_bit_zero, addr_select_bit_one,
		sda_miso_in, link_clk, rx_tgl_r};

	ccp_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.sys_ce  (sys_ce),
		.pins    (pin_if.sync)
	);

	assign {pd_n_s, ss_n_s, a1_s, sda_s, scl_s, tgl_s} = pin_if.clean;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{scl_q_r, sda_q_r, ss_q_r, tgl_q_r} <= 4'hE;
		end else if (sys_ce) begin
			{scl_q_r, sda_q_r, ss_q_r, tgl_q_r} <= {scl_s, sda_s, ss_n_s, tgl_s};
		end
	end

	// Edge decode. A start or stop is seen only with SCL high in both samples around the SDA edge.
	assign scl_rise    = scl_s & ~scl_q_r;
	assign scl_fall    = ~scl_s & scl_q_r;
	assign start_c     = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign stop_c      = scl_s & scl_q_r & ~sda_q_r & sda_s;
	assign ss_fall     = ~ss_n_s & ss_q_r;
	assign ss_rise     = ss_n_s & ~ss_q_r;
	assign i2c_act     = ~spi_mode_r & pd_n_s;
	assign frame_reset = (i2c_act & (start_c | stop_c)) | ss_fall | ss_rise | ~pd_n_s;

	// ****************************************************************
	// Byte decode shared by both port modes
	// ****************************************************************
	assign i2c_evt    = i2c_act & (i2c_st_r == I2_RX) & scl_fall & (bitc_r == BITS_PER_SLOT);
	assign spi_evt    = spi_live_r & (tgl_s != tgl_q_r);
	assign evt        = i2c_evt | spi_evt;
	assign evt_byte   = spi_mode_r ? rx_hold_r : shift_r;
	assign full_sub   = {sub_r[7:0], evt_byte};
	assign addr_match = (evt_byte[7:1] == {DEV_ADDR_UPPER, a1_s, ss_n_s});
	assign wr_over    = sub_r > SUB_HIGHEST;
	// SPI accepts any first byte; only its direction bit matters.
	assign accept     = (phase_r == PH_CTRL) ? (spi_mode_r | addr_match) :
		(phase_r == PH_SUBL) ? ccp_sub_valid(full_sub) :
		(phase_r == PH_DATA) ? (rd_r | ~wr_over) : 1'b1;
	assign take       = evt & accept;
	assign phase_nxt  = (phase_r == PH_CTRL) ? ((~spi_mode_r & evt_byte[0]) ? PH_DATA : PH_SUBH) :
		(phase_r == PH_SUBH) ? PH_SUBL : PH_DATA;
	assign wr_go      = take & (phase_r == PH_DATA) & ~rd_r;
	assign mack_ok    = i2c_act & (i2c_st_r == I2_MACK) & scl_rise & ~sda_s;
	assign rd_go      = (take & ~spi_mode_r & (phase_r == PH_CTRL) & evt_byte[0]) | mack_ok
		| (take & spi_mode_r & rd_r & ((phase_r == PH_SUBL) | (phase_r == PH_DATA)));
	assign step       = wr_go | rd_go;
	// An SPI read starts on the low subaddress byte, before sub_r holds the new address.
	assign sub_load   = take & (phase_r == PH_SUBL);
	assign cur_sub    = sub_load ? full_sub : sub_r;
	assign cur_len    = sub_load ? ccp_word_len(full_sub) : wlen_r;
	assign cur_bidx   = sub_load ? 2'h0 : bidx_r;
	assign word_end   = ({1'b0, cur_bidx} == (cur_len - 3'h1));
	assign hold_top   = rd_go & (cur_sub == SUB_HIGHEST);
	assign bidx_nxt   = word_end ? 2'h0 : cur_bidx + 2'h1;
	assign sub_step   = (word_end & ~hold_top) ? cur_sub + 16'h0001 : cur_sub;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			phase_r <= PH_CTRL;
			rd_r    <= 1'b0;
		end else if (sys_ce) begin
			if (frame_reset | (evt & ~accept)) begin
				phase_r <= PH_CTRL;
			end else if (take) begin
				phase_r <= phase_nxt;
			end
			if (take & (phase_r == PH_CTRL)) begin
				rd_r <= evt_byte[0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sub_r  <= SUB_RST;
			bidx_r <= 2'h0;
			wlen_r <= WLEN_REG;
		end else if (sys_ce) begin
			if (take & (phase_r == PH_SUBH)) begin
				sub_r <= full_sub;
			end else if (step | sub_load) begin
				sub_r  <= step ? sub_step : full_sub;
				bidx_r <= step ? bidx_nxt : 2'h0;
			end
			if (sub_load) begin
				wlen_r <= cur_len;
			end
		end
	end

	// ****************************************************************
	// Memory access port
	// ****************************************************************
	// Reserved locations are the memory's business; writes pass through unfiltered up to SUB_HIGHEST.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{mem_wr_r, mem_rd_r} <= 2'h0;
			mem_addr_r           <= SUB_RST;
			mem_byte_r           <= 2'h0;
			mem_wdata_r          <= 8'h00;
			tx_byte_r            <= 8'h00;
		end else if (sys_ce) begin
			{mem_wr_r, mem_rd_r} <= {wr_go, rd_go};
			if (step) begin
				{mem_addr_r, mem_byte_r} <= {cur_sub, cur_bidx};
			end
			if (wr_go) begin
				mem_wdata_r <= evt_byte;
			end
			if (mem_rd_r) begin
				tx_byte_r <= mem_rdata;
			end
		end
	end

	// ****************************************************************
	// I2C bit engine
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			i2c_st_r  <= I2_IDLE;
			bitc_r    <= 4'h0;
			shift_r   <= 8'h00;
			txsh_r    <= 8'hFF;
			sda_oe_r  <= 1'b0;
			sda_out_r <= 1'b0;
		end else if (sys_ce) begin
			sda_out_r <= 1'b0;
			if (~i2c_act | stop_c) begin
				i2c_st_r <= I2_IDLE;
				sda_oe_r <= 1'b0;
			end else if (start_c) begin
				i2c_st_r <= I2_RX;
				bitc_r   <= 4'h0;
				sda_oe_r <= 1'b0;
			end else begin
				unique case (i2c_st_r)
					I2_IDLE: begin
					end
					I2_RX: begin
						if (scl_rise) begin
							shift_r <= {shift_r[6:0], sda_s};
							bitc_r  <= bitc_r + 4'h1;
						end else if (i2c_evt) begin
							i2c_st_r <= accept ? I2_ACK : I2_IDLE;
							sda_oe_r <= accept;
						end
					end
					I2_ACK: begin
						if (scl_fall) begin
							i2c_st_r <= rd_r ? I2_TX : I2_RX;
							bitc_r   <= 4'h0;
							sda_oe_r <= rd_r & ~tx_byte_r[7];
							txsh_r   <= {tx_byte_r[6:0], 1'b1};
						end
					end
					I2_TX: begin
						if (scl_rise) begin
							bitc_r <= bitc_r + 4'h1;
						end else if (scl_fall & (bitc_r == BITS_PER_SLOT)) begin
							i2c_st_r <= I2_MACK;
							sda_oe_r <= 1'b0;
						end else if (scl_fall) begin
							sda_oe_r <= ~txsh_r[7];
							txsh_r   <= {txsh_r[6:0], 1'b1};
						end
					end
					I2_MACK: begin
						if (scl_rise & sda_s) begin
							i2c_st_r <= I2_IDLE;
						end else if (scl_fall) begin
							i2c_st_r <= I2_TX;
							bitc_r   <= 4'h0;
							sda_oe_r <= ~tx_byte_r[7];
							txsh_r   <= {tx_byte_r[6:0], 1'b1};
						end
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// SPI mode entry and frame tracking
	// ****************************************************************
	// Mode flips on the third fall, but only a fall seen in SPI mode opens a frame,
	// so the third transfer is ignored like the first two.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			spi_mode_r <= 1'b0;
			spi_cnt_r  <= 2'h0;
			spi_live_r <= 1'b0;
		end else if (sys_ce) begin
			if (~pd_n_s) begin
				spi_mode_r <= 1'b0;
				spi_cnt_r  <= 2'h0;
			end else if (~spi_mode_r & ss_fall) begin
				spi_cnt_r  <= spi_cnt_r + 2'h1;
				spi_mode_r <= (spi_cnt_r == SPI_ENTRY_FALLS - 2'h1);
			end
			if (~spi_mode_r | ss_rise | (spi_evt & ~accept)) begin
				spi_live_r <= 1'b0;
			end else if (ss_fall) begin
				spi_live_r <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// SPI link domain
	// ****************************************************************
	// SCLK only runs inside frames, so select high holds this logic in reset.
	// The toggle and received byte survive frames so no false event reaches sys_clk.
	assign link_frame_rst = addr_select_bit_zero | ~spi_mode_r;
	assign link_mode_rst  = ~spi_mode_r;

	always_ff @(posedge link_clk or posedge link_frame_rst) begin
		if (link_frame_rst) begin
			bitl_r  <= 3'h0;
			bytel_r <= 2'h0;
			rx_sh_r <= 7'h00;
			rdl_r   <= 1'b0;
		end else begin
			rx_sh_r <= {rx_sh_r[5:0], addr_select_bit_one};
			bitl_r  <= bitl_r + 3'h1;
			if ((bitl_r == LINK_LAST_BIT) && (bytel_r != SPI_DATA_BYTE)) begin
				bytel_r <= bytel_r + 2'h1;
			end
			if ((bitl_r == LINK_LAST_BIT) && (bytel_r == 2'h0)) begin
				rdl_r <= addr_select_bit_one;
			end
		end
	end

	always_ff @(posedge link_clk or posedge link_mode_rst) begin
		if (link_mode_rst) begin
			rx_hold_r <= 8'h00;
			rx_tgl_r  <= 1'b0;
		end else if (~addr_select_bit_zero && (bitl_r == LINK_LAST_BIT)) begin
			rx_hold_r <= {rx_sh_r, addr_select_bit_one};
			rx_tgl_r  <= ~rx_tgl_r;
		end
	end

	// The read byte is taken from sys_clk at each byte start; it must have settled by then.
	always_ff @(negedge link_clk or posedge link_frame_rst) begin
		if (link_frame_rst) begin
			miso_r    <= 1'b0;
			miso_oe_r <= 1'b0;
			txl_r     <= 8'h00;
		end else if (bitl_r == 3'h0) begin
			miso_r    <= tx_byte_r[7];
			txl_r     <= {tx_byte_r[6:0], 1'b0};
			miso_oe_r <= rdl_r & (bytel_r == SPI_DATA_BYTE);
		end else begin
			miso_r <= txl_r[7];
			txl_r  <= {txl_r[6:0], 1'b0};
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign i2c_sda_out  = sda_out_r;
	assign i2c_sda_oe   = sda_oe_r;
	assign spi_miso_out = miso_r;
	assign spi_miso_oe  = miso_oe_r;
	assign spi_mode     = spi_mode_r;
	assign mem_wr       = mem_wr_r;
	assign mem_rd       = mem_rd_r;
	assign mem_addr     = mem_addr_r;
	assign mem_byte     = mem_byte_r;
	assign mem_wdata    = mem_wdata_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb_sys @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	addr_ack_a: assert property (
		sys_ce && i2c_evt && phase_r == PH_CTRL && addr_match |=> i2c_st_r == I2_ACK && i2c_sda_oe)
		else $error("matching address not acknowledged");
	bad_sub_a: assert property (
		sys_ce && i2c_evt && phase_r == PH_SUBL && !ccp_sub_valid(full_sub)
		|=> i2c_st_r == I2_IDLE && !i2c_sda_oe)
		else $error("invalid subaddress was acknowledged");
	stop_idle_a: assert property (
		sys_ce && i2c_act && stop_c |=> i2c_st_r == I2_IDLE && !i2c_sda_oe)
		else $error("stop did not return the port to idle");
	start_restart_a: assert property (
		sys_ce && i2c_act && start_c |=> i2c_st_r == I2_RX && bitc_r == 4'h0 && phase_r == PH_CTRL)
		else $error("start did not restart address reception");
	wr_overrun_a: assert property (
		sys_ce && evt && phase_r == PH_DATA && !rd_r && wr_over |=> !mem_wr && !i2c_sda_oe)
		else $error("write past highest subaddress was stored");
	rd_top_a: assert property (
		sys_ce && rd_go && cur_sub == SUB_HIGHEST |=> sub_r == SUB_HIGHEST)
		else $error("read moved past highest subaddress");
	word_hold_a: assert property (
		sys_ce && step && !word_end |=> sub_r == $past(cur_sub) && bidx_r == $past(cur_bidx) + 2'h1)
		else $error("subaddress advanced inside a word");
	spi_enter_a: assert property (
		sys_ce && pd_n_s && !spi_mode_r && ss_fall && spi_cnt_r != 2'h2 |=> !spi_mode_r)
		else $error("SPI mode entered before third select");
	spi_stay_a: assert property (
		spi_mode_r && pd_n_s ##1 sys_ce |-> spi_mode_r)
		else $error("SPI mode left without power down");
	write_pulse_a: assert property (
		sys_ce && i2c_evt && phase_r == PH_DATA && !rd_r && !wr_over |=> mem_wr ##1 !mem_wr[*2])
		else $error("accepted write byte not stored once");

	i2c_write_c: cover property (sys_ce && mem_wr && !spi_mode_r);
	i2c_read_c:  cover property (sys_ce && mack_ok ##[1:200] i2c_st_r == I2_TX);
	spi_entry_c: cover property (!spi_mode_r ##1 spi_mode_r);
	overrun_c:   cover property (sys_ce && evt && phase_r == PH_DATA && !rd_r && wr_over);

endmodule : ccp_port

// ===== tb/ccp_host.sv
// Host model that masters the control port as I2C or as 4-wire SPI.
`timescale 1ns/1ps
module ccp_host (
	// Clocking
	input  wire logic sys_clk,
	// Pins driven by the host
	output logic      scl,
	output logic      sda_o,
	output logic      mosi,
	output logic      ss_n,
	// Lines read back
	input  wire logic sda,
	input  wire logic miso
);
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
		mosi = 1'b0;
		ss_n = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wt
	// SDA only moves in mid-low so it never looks like a start or stop.
	task automatic bitx(input logic b, output logic r);
		wt(5);
		sda_o = b;
		wt(5);
		scl = 1'b1;
		wt(10);
		r = sda;
		scl = 1'b0;
	endtask : bitx
	// Also serves as repeated start.
	task automatic start;
		wt(5);
		sda_o = 1'b1;
		wt(5);
		scl = 1'b1;
		wt(10);
		sda_o = 1'b0;
		wt(10);
		scl = 1'b0;
	endtask : start
	task automatic stop;
		wt(5);
		sda_o = 1'b0;
		wt(5);
		scl = 1'b1;
		wt(10);
		sda_o = 1'b1;
		wt(10);
	endtask : stop
	// Ninth bit 1 releases SDA; 0 is the master acknowledge.
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
	endtask : xfer
	// SCLK stands high between frames; the pause after each byte lets read data settle.
	task automatic spi(input int n, input logic [31:0] tx, output logic [7:0] rx);
		ss_n = 1'b0;
		#40;
		for (int k = n - 1; k >= 0; k--) begin
			for (int i = 7; i >= 0; i--) begin
				scl = 1'b0;
				mosi = tx[8*k+i];
				#16;
				scl = 1'b1;
				rx[i] = miso;
				#16;
			end
			wt(12);
		end
		ss_n = 1'b1;
		mosi = ~mosi;
	endtask : spi
endmodule : ccp_host

// ===== tb/ccp_port_bench.sv
// Self-checking bench of the control port slave.
`timescale 1ns/1ps
module ccp_port_bench;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        pd_n    = 1'b1;
	logic        ce      = 1'b1;
	logic        sda_hi  = 1'b0;
	logic        sda_out, mem_rd;
	logic        scl, sda_o, mosi, ss_n, sda_oe, miso_out, miso_oe, spi_mode, mem_wr;
	logic [15:0] mem_addr, wr_a, rd_a;
	logic [1:0]  mem_byte, wr_b;
	logic [7:0]  mem_wdata, wr_d, rx, na;
	logic [8:0]  q;
	int          errors = 0;
	int          check_count = 0;
	wire         sda   = sda_oe ? 1'b0 : sda_o;
	wire         miso  = miso_oe ? miso_out : 1'bz;
	wire  [7:0]  rdata = mem_addr[7:0] ^ {6'h00, mem_byte};
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (mem_wr) begin
		wr_a <= mem_addr;
		wr_b <= mem_byte;
		wr_d <= mem_wdata;
	end
	always @(posedge sys_clk) begin
		if (mem_rd) rd_a <= mem_addr;
		if (!sys_rst && sda_out !== 1'b0) sda_hi <= 1'b1;
	end
	ccp_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sys_ce(ce), .link_clk(scl),
		.sda_miso_in(sda), .addr_select_bit_one(mosi), .addr_select_bit_zero(ss_n),
		.power_down_n_pin(pd_n), .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe),
		.spi_miso_out(miso_out),
		.spi_miso_oe(miso_oe), .spi_mode(spi_mode), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_byte(mem_byte), .mem_wdata(mem_wdata), .mem_rdata(rdata));
	ccp_host host (.sys_clk(sys_clk), .scl(scl), .sda_o(sda_o), .mosi(mosi), .ss_n(ss_n),
		.sda(sda), .miso(miso));
	// ****
	// Checking and I2C helpers
	// ****
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic summarize;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize
	// Sends n bytes, first byte highest in v; na holds one bit per byte, 1 = no acknowledge.
	task automatic i2w(input int n, input logic [63:0] v);
		na = 8'h00;
		host.start;
		for (int k = n - 1; k >= 0; k--) begin
			host.xfer({v[8*k+:8], 1'b1}, q);
			na[k] = q[0];
		end
		host.stop;
	endtask : i2w
	// ****
	// Scenarios
	// ****
	task automatic t_i2c_wr;
		i2w(4, {8'h7A, 16'hC005, 8'hA5});
		check("write acks", na, 16'h0000);
		check("write addr", wr_a, 16'hC005);
		check("write data", wr_d, 16'h00A5);
		i2w(8, {8'h7A, 16'h0080, 40'h1112131415});
		check("burst acks", na, 16'h0000);
		check("burst addr", wr_a, 16'h0081);
		check("burst byte", wr_b, 16'h0000);
		i2w(5, {8'h7A, 16'hC040, 8'h21, 8'h22});
		check("overrun acks", na, 16'h0001);
		check("overrun data", wr_d, 16'h0021);
		i2w(2, {8'h7C, 8'hC0});
		check("mismatch acks", na, 16'h0003);
		i2w(3, {8'h7A, 16'h0300});
		check("invalid sub acks", na, 16'h0001);
	endtask : t_i2c_wr
	task automatic t_i2c_rd;
		i2w(3, {8'h7A, 16'hC03F});
		host.start;
		host.xfer(9'h0F7, q);
		check("read addr ack", q[0], 16'h0000);
		host.xfer(9'h1FE, q);
		check("read byte 1", q[8:1], 16'h003F);
		host.xfer(9'h1FE, q);
		check("read byte 2", q[8:1], 16'h0040);
		host.xfer(9'h1FF, q);
		check("read past top", q[8:1], 16'h0040);
		host.stop;
		check("read addr last", rd_a, 16'hC040);
		check("sda drive level", sda_hi, 16'h0000);
	endtask : t_i2c_rd
	task automatic t_spi;
		int i;
		repeat (3) begin
			host.spi(1, 32'h0, rx);
			host.wt(10);
		end
		for (i = 0; i < 20 && spi_mode !== 1'b1; i++) host.wt(1);
		check("spi mode", spi_mode, 16'h0001);
		if (spi_mode !== 1'b1) summarize();
		host.spi(4, 32'hFEC0075A, rx);
		host.wt(10);
		check("spi wr addr", wr_a, 16'hC007);
		check("spi wr data", wr_d, 16'h005A);
		check("miso float", rx, 16'h00ZZ);
		host.spi(4, 32'h5BC01200, rx);
		check("spi rd data", rx, 16'h0012);
		check("spi rd addr", rd_a, 16'hC013);
		ce = 1'b0;
		pd_n = 1'b0;
		host.wt(8);
		check("spi frozen", spi_mode, 16'h0001);
		ce = 1'b1;
		host.wt(8);
		pd_n = 1'b1;
		host.wt(8);
		check("spi exit", spi_mode, 16'h0000);
		i2w(1, {56'h0, 5'h0F, mosi, ss_n, 1'b0});
		check("i2c after exit", na, 16'h0000);
	endtask : t_spi
	initial begin
		repeat (100000) @(posedge sys_clk);
		errors++;
		summarize();
	end
	initial begin
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		host.wt(8);
		t_i2c_wr();
		t_i2c_rd();
		t_spi();
		summarize();
	end
endmodule : ccp_port_bench
